// ---- design/pmr_pkg.sv ----
package pmr_pkg;
    localparam logic [3:0] CONTROL_PORT = 4'hf;
    localparam logic [15:0] REG_LINK_STATUS = 16'h0000;
    localparam logic [15:0] REG_LINK_ERROR = 16'h0001;
    localparam logic [15:0] REG_LINK_CONTROL = 16'h0002;
    localparam logic [15:0] REG_ACTIVE_TAGS = 16'h0003;
    localparam logic [15:0] REG_NOTIFICATION = 16'h0004;
    localparam logic [15:0] REG_VENDOR_FIRST = 16'h0080;
    localparam logic [15:0] REG_VENDOR_LAST = 16'h00ff;
    localparam logic [15:0] REG_COUNTER_FIRST = 16'h0100;
    localparam logic [15:0] REG_COUNTER_LAST = 16'h08ff;
    localparam logic [3:0] DETECT_CONTROL_LSB = 4'h0;
    localparam logic [3:0] DETECT_PHY_DISABLED = 4'h4;
    localparam logic [31:0] LINK_CONTROL_RESET = 32'h00000004;
    localparam logic [63:0] COUNT_RESET = 64'h0000000000000000;

    typedef struct packed {
        logic write;
        logic [3:0] port;
        logic [15:0] reg_num;
        logic value_select;
        logic clear_after_read;
        logic [63:0] wdata;
    } pmr_cmd_t;

    typedef struct packed {
        logic valid;
        logic error;
        logic [63:0] rdata;
    } pmr_rsp_t;
endpackage : pmr_pkg

// ---- design/pmr_counter.sv ----
`timescale 1ns/1ns
module pmr_counter #(
    parameter logic [15:0] EVENT_ID = 16'h0001,
    parameter int WIDTH = 32
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic event_in,
    input wire logic load_in,
    input wire logic [63:0] load_value_in,
    input wire logic clear_in,
    output logic [15:0] id_out,
    output logic [63:0] value_out
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic saturated;

    assign saturated = &count;
    // Write wins; an event in the cycle of a clear still counts; saturate rather than wrap
    assign next_count = load_in ? load_value_in[WIDTH-1:0] :
                        clear_in ? WIDTH'(event_in) :
                        (event_in && !saturated) ? count + 1'b1 : count;
    assign id_out = EVENT_ID;
    assign value_out = 64'(count);

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            count <= pmr_pkg::COUNT_RESET[WIDTH-1:0];
        end else begin
            count <= next_count;
        end
    end
endmodule : pmr_counter

// ---- design/pmr_register_map.sv ----
`timescale 1ns/1ns
module pmr_register_map #(
    parameter int NUM_PORTS = 4,
    parameter int NUM_COUNTERS = 2,
    parameter int COUNT_WIDTH = 32
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire pmr_pkg::pmr_cmd_t cmd_in,
    input wire logic [NUM_PORTS*32-1:0] link_status_in,
    input wire logic [NUM_PORTS*32-1:0] link_error_set_in,
    input wire logic [NUM_COUNTERS-1:0] host_event_in,
    input wire logic [NUM_PORTS*NUM_COUNTERS-1:0] port_event_in,
    output pmr_pkg::pmr_rsp_t rsp_out,
    output logic [NUM_PORTS*32-1:0] link_control_out
);
    // =====================================================
    // Decode
    // =====================================================
    localparam int NSETS = NUM_PORTS + 1;
    localparam int HOST_SET = NUM_PORTS;

    function automatic logic is_counter(input logic [15:0] r);
        is_counter = (r >= pmr_pkg::REG_COUNTER_FIRST) &&
                     (r < pmr_pkg::REG_COUNTER_FIRST + 16'(NUM_COUNTERS));
    endfunction : is_counter

    logic to_control;
    logic port_ok;
    logic set_ok;
    logic [3:0] set_sel;
    logic [15:0] cnt_idx_full;
    logic [7:0] cnt_idx;
    logic hit_counter;
    logic hit_status;
    logic hit_error;
    logic hit_control;
    logic [NSETS*NUM_COUNTERS-1:0] cnt_sel;
    logic [NSETS*NUM_COUNTERS*16-1:0] cnt_id;
    logic [NSETS*NUM_COUNTERS*64-1:0] cnt_val;
    logic [NSETS*NUM_COUNTERS-1:0] cnt_event;
    logic [63:0] sel_rdata;
    logic [63:0] cnt_rdata;
    logic [31:0] port_rdata;
    logic [NUM_PORTS*32-1:0] link_error;
    logic [NUM_PORTS*32-1:0] link_control;
    logic cnt_write;
    logic cnt_clear;

    assign to_control = (cmd_in.port == pmr_pkg::CONTROL_PORT);
    assign port_ok = (32'(cmd_in.port) < NUM_PORTS);
    // Control port selects global set, any other valid port its own set
    assign set_sel = to_control ? 4'(HOST_SET) : cmd_in.port;
    assign set_ok = to_control || port_ok;
    assign cnt_idx_full = cmd_in.reg_num - pmr_pkg::REG_COUNTER_FIRST;
    assign cnt_idx = cnt_idx_full[7:0];
    assign hit_counter = set_ok && is_counter(cmd_in.reg_num);
    assign hit_status = port_ok && !to_control && (cmd_in.reg_num == pmr_pkg::REG_LINK_STATUS);
    assign hit_error = port_ok && !to_control && (cmd_in.reg_num == pmr_pkg::REG_LINK_ERROR);
    assign hit_control = port_ok && !to_control && (cmd_in.reg_num == pmr_pkg::REG_LINK_CONTROL);
    assign cnt_write = cmd_valid_in && cmd_in.write && hit_counter;
    assign cnt_clear = cmd_valid_in && !cmd_in.write && hit_counter &&
                       cmd_in.value_select && cmd_in.clear_after_read;

    // =====================================================
    // Event counters, one bank per set
    // =====================================================
    genvar gs;
    genvar gc;
    generate
        for (gs = 0; gs < NSETS; gs++) begin : g_set
            for (gc = 0; gc < NUM_COUNTERS; gc++) begin : g_cnt
                localparam int K = gs * NUM_COUNTERS + gc;
                assign cnt_sel[K] = (set_sel == 4'(gs)) && (cnt_idx == 8'(gc));
                if (gs == HOST_SET) begin : g_host
                    assign cnt_event[K] = host_event_in[gc];
                end else begin : g_port
                    assign cnt_event[K] = port_event_in[gs*NUM_COUNTERS+gc];
                end
                pmr_counter #(
                    .EVENT_ID(16'(gc + 1)),
                    .WIDTH(COUNT_WIDTH)
                ) u_counter (
                    .core_clk_in(core_clk_in),
                    .rst_in(rst_in),
                    .event_in(cnt_event[K]),
                    .load_in(cnt_write && cnt_sel[K]),
                    .load_value_in(cmd_in.wdata),
                    .clear_in(cnt_clear && cnt_sel[K]),
                    .id_out(cnt_id[K*16 +: 16]),
                    .value_out(cnt_val[K*64 +: 64])
                );
            end
        end
    endgenerate

    always_comb begin
        cnt_rdata = 64'h0;
        for (int k = 0; k < NSETS * NUM_COUNTERS; k++) begin
            if (cnt_sel[k]) begin
                cnt_rdata = cmd_in.value_select ? cnt_val[k*64 +: 64] : 64'(cnt_id[k*16 +: 16]);
            end
        end
    end

    // =====================================================
    // Per-port link registers
    // =====================================================
    generate
        for (gs = 0; gs < NUM_PORTS; gs++) begin : g_link
            logic sel;
            logic [31:0] error_bits;
            logic [31:0] control_bits;
            logic [31:0] next_error;
            logic [31:0] next_control;
            assign sel = cmd_valid_in && cmd_in.write && (set_sel == 4'(gs));
            // Hardware set wins over write-one-to-clear
            assign next_error = (sel && hit_error) ?
                ((error_bits & ~cmd_in.wdata[31:0]) | link_error_set_in[gs*32 +: 32]) :
                (error_bits | link_error_set_in[gs*32 +: 32]);
            assign next_control = (sel && hit_control) ? cmd_in.wdata[31:0] : control_bits;
            assign link_error[gs*32 +: 32] = error_bits;
            assign link_control[gs*32 +: 32] = control_bits;
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    error_bits <= 32'h0;
                    control_bits <= pmr_pkg::LINK_CONTROL_RESET;
                end else begin
                    error_bits <= next_error;
                    control_bits <= next_control;
                end
            end
        end
    endgenerate

    always_comb begin
        port_rdata = 32'h0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (set_sel == 4'(p)) begin
                if (hit_status) begin
                    port_rdata = link_status_in[p*32 +: 32];
                end else if (hit_error) begin
                    port_rdata = link_error[p*32 +: 32];
                end else if (hit_control) begin
                    port_rdata = link_control[p*32 +: 32];
                end
            end
        end
    end

    // Vendor, unimplemented and reserved numbers fall through to zero
    assign sel_rdata = hit_counter ? cnt_rdata : 64'(port_rdata);

    // =====================================================
    // Response
    // =====================================================
    pmr_pkg::pmr_rsp_t next_rsp;
    always_comb begin
        next_rsp = '0;
        next_rsp.valid = cmd_valid_in;
        next_rsp.error = cmd_valid_in && !set_ok;
        next_rsp.rdata = (cmd_valid_in && !cmd_in.write) ? sel_rdata : 64'h0;
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_out <= '0;
            link_control_out <= {NUM_PORTS{pmr_pkg::LINK_CONTROL_RESET}};
        end else begin
            rsp_out <= next_rsp;
            link_control_out <= link_control;
        end
    end
endmodule : pmr_register_map

// ---- verif/pmr_register_map_asserts.sv ----
`timescale 1ns/1ns
module pmr_register_map_asserts #(
    parameter int NUM_PORTS = 4,
    parameter int NUM_COUNTERS = 2,
    parameter int COUNT_WIDTH = 32
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire pmr_pkg::pmr_cmd_t cmd_in,
    input wire logic [NUM_PORTS*32-1:0] link_status_in,
    input wire logic [NUM_PORTS*32-1:0] link_error_set_in,
    input wire logic [NUM_COUNTERS-1:0] host_event_in,
    input wire logic [NUM_PORTS*NUM_COUNTERS-1:0] port_event_in,
    input wire pmr_pkg::pmr_rsp_t rsp_out,
    input wire logic [NUM_PORTS*32-1:0] link_control_out
);
    // ====================
    // Checks
    wire logic rd = cmd_valid_in && !cmd_in.write;
    wire logic in_port = cmd_in.port < NUM_PORTS;
    wire logic is_cnt = cmd_in.reg_num >= 16'h0100 && cmd_in.reg_num < 16'h0100 + NUM_COUNTERS;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    chk_rsp_next: assert property (cmd_valid_in |=> rsp_out.valid) else $error("no response");
    chk_rsp_cause: assert property (rsp_out.valid |-> $past(cmd_valid_in)) else $error("stray response");
    chk_port_refuse: assert property (
        cmd_valid_in && !in_port && cmd_in.port != 4'hf |=> rsp_out.error && rsp_out.rdata == 64'h0)
        else $error("bad port accepted");
    chk_write_zero: assert property (
        cmd_valid_in && cmd_in.write |=> rsp_out.rdata == 64'h0)
        else $error("write returned data");
    chk_rsvd_port: assert property (
        rd && in_port && cmd_in.reg_num inside {[16'h0003:16'h00ff], [16'h0900:16'hffff]}
        |=> rsp_out.rdata == 64'h0) else $error("port reserved nonzero");
    chk_rsvd_global: assert property (
        rd && cmd_in.port == 4'hf && cmd_in.reg_num inside {[16'h0080:16'h00ff], [16'h0900:16'hffff]}
        |=> rsp_out.rdata == 64'h0) else $error("global reserved nonzero");
    chk_status_read: assert property (
        rd && in_port && cmd_in.reg_num == 16'h0000
        |=> rsp_out.rdata == {32'h0, $past(link_status_in[cmd_in.port*32+:32])}) else $error("status");
    chk_ctrl_follow: assert property (
        cmd_valid_in && cmd_in.write && in_port && cmd_in.reg_num == 16'h0002
        |=> ##1 link_control_out[$past(cmd_in.port, 2)*32+:32] == $past(cmd_in.wdata[31:0], 2))
        else $error("control copy");
    chk_id_read: assert property (
        rd && in_port && is_cnt && !cmd_in.value_select
        |=> rsp_out.rdata == 64'($past(cmd_in.reg_num) - 16'h00ff)) else $error("counter id");
    chk_detect_reset: assert property (
        $fell(rst_in) |-> link_control_out[3:0] == 4'h4)
        else $error("detect reset");
endmodule : pmr_register_map_asserts
bind pmr_register_map pmr_register_map_asserts #(.NUM_PORTS(NUM_PORTS), .NUM_COUNTERS(NUM_COUNTERS),
    .COUNT_WIDTH(COUNT_WIDTH)) chk_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .link_status_in(link_status_in), .link_error_set_in(link_error_set_in),
    .host_event_in(host_event_in), .port_event_in(port_event_in), .rsp_out(rsp_out),
    .link_control_out(link_control_out));

// ---- verif/pmr_host_model.sv ----
`timescale 1ns/1ns
module pmr_host_model (
    input wire logic core_clk_in,
    input wire pmr_pkg::pmr_rsp_t rsp_in,
    output logic cmd_valid_out,
    output pmr_pkg::pmr_cmd_t cmd_out
);
    // ====================
    // One command, answer taken one edge later
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
    end
    task automatic xfer(input pmr_pkg::pmr_cmd_t cmd, output pmr_pkg::pmr_rsp_t rsp);
        @(posedge core_clk_in);
        #1;
        cmd_valid_out = 1'b1;
        cmd_out = cmd;
        @(posedge core_clk_in);
        #1;
        cmd_valid_out = 1'b0;
        cmd_out = ~cmd;
        rsp = rsp_in;
    endtask : xfer
endmodule : pmr_host_model

// ---- verif/tb.sv ----
`timescale 1ns/1ns
module tb;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic cmd_valid_in;
    pmr_pkg::pmr_cmd_t cmd_in;
    pmr_pkg::pmr_rsp_t rsp_out;
    logic [63:0] link_status_in = '0;
    logic [63:0] link_error_set_in = '0;
    logic [1:0] host_event_in = '0;
    logic [3:0] port_event_in = '0;
    logic [63:0] link_control_out;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 core_clk_in = ~core_clk_in;
    pmr_register_map #(.NUM_PORTS(2), .NUM_COUNTERS(2), .COUNT_WIDTH(32)) dut_u (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .link_status_in(link_status_in),
        .link_error_set_in(link_error_set_in), .host_event_in(host_event_in), .port_event_in(port_event_in),
        .rsp_out(rsp_out), .link_control_out(link_control_out));
    pmr_host_model host_u (.core_clk_in(core_clk_in), .rsp_in(rsp_out), .cmd_valid_out(cmd_valid_in),
        .cmd_out(cmd_in));
    // ====================
    // Shared tasks
    task automatic results();
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic acc(input string what, input logic w, input logic [3:0] p, input logic [15:0] r,
        input logic [1:0] sel, input logic [63:0] wd, input logic [63:0] exp);
        pmr_pkg::pmr_rsp_t s;
        host_u.xfer('{w, p, r, sel[1], sel[0], wd}, s);
        check({what, "_st"}, {62'h0, 1'b1, p != 4'hf && p > 4'h1}, {62'h0, s.valid, s.error});
        check(what, exp, s.rdata);
    endtask : acc
    // ====================
    // Scenarios
    task automatic t_reserved();
        logic [15:0] rp [6] = '{16'h0003, 16'h0004, 16'h0005, 16'h00ff, 16'h0900, 16'hffff};
        foreach (rp[i]) begin
            acc("rsvw", 1'b1, 4'h0, rp[i], 2'h0, 64'hffffffff, 64'h0);
            acc("rsv", 1'b0, 4'h0, rp[i], 2'h3, 64'h0, 64'h0);
            acc("glb", 1'b0, 4'hf, rp[i] < 16'h0100 ? 16'h0080 : rp[i], 2'h0, 64'h0, 64'h0);
        end
        acc("badp", 1'b1, 4'h5, 16'h0002, 2'h0, 64'h1, 64'h0);
    endtask : t_reserved
    task automatic t_control();
        acc("ctl0", 1'b0, 4'h0, 16'h0002, 2'h0, 64'h0, 64'h4);
        acc("ctlw", 1'b1, 4'h1, 16'h0002, 2'h0, 64'h5a5a0001, 64'h0);
        acc("ctl1", 1'b0, 4'h1, 16'h0002, 2'h0, 64'h0, 64'h5a5a0001);
        acc("ctl0b", 1'b0, 4'h0, 16'h0002, 2'h0, 64'h0, 64'h4);
        check("ctlout", 64'h5a5a000100000004, link_control_out);
    endtask : t_control
    task automatic t_status_error();
        link_status_in = 64'h0000011300000123;
        link_error_set_in = 64'h0000000000000001;
        acc("sts0", 1'b0, 4'h0, 16'h0000, 2'h0, 64'h0, 64'h123);
        link_error_set_in = '0;
        acc("sts1", 1'b0, 4'h1, 16'h0000, 2'h0, 64'h0, 64'h113);
        acc("err", 1'b0, 4'h0, 16'h0001, 2'h0, 64'h0, 64'h1);
        acc("errc", 1'b1, 4'h0, 16'h0001, 2'h0, 64'h1, 64'h0);
        acc("err0", 1'b0, 4'h0, 16'h0001, 2'h0, 64'h0, 64'h0);
    endtask : t_status_error
    task automatic t_counters();
        acc("id0", 1'b0, 4'h1, 16'h0100, 2'h0, 64'h0, 64'h1);
        acc("id1", 1'b0, 4'hf, 16'h0101, 2'h0, 64'h0, 64'h2);
        acc("pv0", 1'b0, 4'h1, 16'h0100, 2'h2, 64'h0, 64'h0);
        repeat (3) begin
            @(posedge core_clk_in) #1 {host_event_in, port_event_in} = 6'h24;
            @(posedge core_clk_in) #1 {host_event_in, port_event_in} = 6'h00;
        end
        acc("pv3", 1'b0, 4'h1, 16'h0100, 2'h3, 64'h0, 64'h3);
        acc("pvc", 1'b0, 4'h1, 16'h0100, 2'h2, 64'h0, 64'h0);
        fork
            acc("pvx", 1'b0, 4'h1, 16'h0100, 2'h3, 64'h0, 64'h0);
            begin
                @(posedge core_clk_in) #1 port_event_in = 4'h4;
                @(posedge core_clk_in) #1 port_event_in = 4'h0;
            end
        join
        acc("pv1", 1'b0, 4'h1, 16'h0100, 2'h2, 64'h0, 64'h1);
        acc("p0", 1'b0, 4'h0, 16'h0100, 2'h2, 64'h0, 64'h0);
        acc("hv", 1'b0, 4'hf, 16'h0101, 2'h2, 64'h0, 64'h3);
        acc("hw", 1'b1, 4'hf, 16'h0101, 2'h0, 64'h7, 64'h0);
        acc("hr", 1'b0, 4'hf, 16'h0101, 2'h2, 64'h0, 64'h7);
    endtask : t_counters
    initial begin
        repeat (10) @(posedge core_clk_in);
        #1 rst_in = 1'b0;
        t_reserved();
        t_control();
        t_status_error();
        t_counters();
        results();
    end
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            results();
        end
    end
endmodule : tb
